// >>> src/aof_pkg.sv
package aof_pkg;
    localparam int DATA_W = 10;
    localparam int PHASE_W = 6;
    localparam int CTRL_W = 8;
    localparam int ADDR_W = 4;
    // Register addresses
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] PHASE_ADDR = 4'h1;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h2;
    // Control word field positions
    localparam int TRISTATE_BIT = 3;
    localparam int TRANSPARENT_BIT = 4;
    localparam int GRAY_BIT = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [PHASE_W-1:0] PHASE_RESET = 6'h00;
    localparam logic [PHASE_W-1:0] PHASE_START = 6'h00;
    localparam logic [PHASE_W-1:0] PHASE_ONE = 6'h01;
endpackage : aof_pkg

// >>> src/aof_formatter.sv
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Normally the result is captured at the programmed output phase.
// - Control bit 4 set makes the output latch transparent.
// - Control bit 3 set releases all data pins (high impedance).
// - Control bit 5 selects Gray code; zero gives straight binary.
module aof_formatter (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [aof_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic pixel_start,
    input wire logic [aof_pkg::DATA_W-1:0] conv_data,
    output logic [aof_pkg::DATA_W-1:0] data_out,
    output logic [aof_pkg::DATA_W-1:0] data_oe
);
    import aof_pkg::*;

    logic [CTRL_W-1:0] frontend_control_word, next_ctrl;
    logic [PHASE_W-1:0] out_phase, next_phase;
    logic [PHASE_W-1:0] phase_cnt, next_cnt;
    logic [DATA_W-1:0] latch, next_latch;
    logic [DATA_W-1:0] next_out;
    logic [31:0] next_rdata;
    logic capture;
    logic transparent;
    logic gray_mode;
    logic tristate;
    logic [DATA_W-1:0] coded;

    assign transparent = frontend_control_word[TRANSPARENT_BIT];
    assign gray_mode = frontend_control_word[GRAY_BIT];
    assign tristate = frontend_control_word[TRISTATE_BIT];

    // Register writes and read data
    always_comb begin
        next_ctrl = frontend_control_word;
        next_phase = out_phase;
        next_rdata = 32'h0000_0000;
        if (reg_write) begin
            if (reg_addr == CTRL_ADDR) begin
                next_ctrl = reg_wdata[CTRL_W-1:0];
            end else if (reg_addr == PHASE_ADDR) begin
                next_phase = reg_wdata[PHASE_W-1:0];
            end
        end
        if (reg_read) begin
            if (reg_addr == CTRL_ADDR) begin
                next_rdata = {{(32-CTRL_W){1'b0}}, frontend_control_word};
            end else if (reg_addr == PHASE_ADDR) begin
                next_rdata = {{(32-PHASE_W){1'b0}}, out_phase};
            end else if (reg_addr == STATUS_ADDR) begin
                next_rdata = {{(32-DATA_W){1'b0}}, latch};
            end
        end
    end

    // Phase counter restarts on each pixel start
    always_comb begin
        if (pixel_start) begin
            next_cnt = PHASE_START;
        end else begin
            next_cnt = phase_cnt + PHASE_ONE;
        end
        capture = (next_cnt == out_phase);
    end

    // Gray conversion
    always_comb begin
        coded = conv_data;
        if (gray_mode) begin
            coded = conv_data ^ (conv_data >> 1);
        end
    end

    always_comb begin
        next_latch = latch;
        if (capture) begin
            next_latch = coded;
        end
        if (transparent) begin
            next_out = coded;
        end else begin
            next_out = next_latch;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            frontend_control_word <= CTRL_RESET;
            out_phase <= PHASE_RESET;
            phase_cnt <= PHASE_START;
            latch <= '0;
            data_out <= '0;
            reg_rdata <= 32'h0000_0000;
        end else begin
            frontend_control_word <= next_ctrl;
            out_phase <= next_phase;
            phase_cnt <= next_cnt;
            latch <= next_latch;
            data_out <= next_out;
            reg_rdata <= next_rdata;
        end
    end

    assign data_oe = tristate ? '0 : '1;

    transparent_follow_a:
    assert property (@(posedge clock) disable iff (!nrst)
        frontend_control_word[TRANSPARENT_BIT] && !$past(reg_write)
        |-> data_out == $past(coded))
        else $error("transparent output mismatch");
    tristate_pins_a:
    assert property (@(posedge clock) disable iff (!nrst)
        tristate |-> data_oe == '0)
        else $error("pins driven in tristate");
    driven_pins_a:
    assert property (@(posedge clock) disable iff (!nrst)
        !tristate |-> data_oe == '1)
        else $error("pins released when enabled");
    gray_msb_a:
    assert property (@(posedge clock) disable iff (!nrst)
        coded[DATA_W-1] == conv_data[DATA_W-1])
        else $error("gray msb changed");
    binary_pass_a:
    assert property (@(posedge clock) disable iff (!nrst)
        !gray_mode |-> coded == conv_data)
        else $error("binary not straight");
    gray_code_a:
    assert property (@(posedge clock) disable iff (!nrst)
        gray_mode |-> coded == (conv_data ^ (conv_data >> 1)))
        else $error("gray code wrong");
    phase_capture_a:
    assert property (@(posedge clock) disable iff (!nrst)
        capture && !transparent |=> data_out == latch)
        else $error("phase capture not presented");
    latch_hold_a:
    assert property (@(posedge clock) disable iff (!nrst)
        !capture |=> latch == $past(latch))
        else $error("latch changed off phase");
    cov_capture_c: cover property (@(posedge clock) capture && !transparent);
    cov_transp_c: cover property (@(posedge clock) transparent);
    cov_gray_c: cover property (@(posedge clock) gray_mode && capture);
    cov_tri_c: cover property (@(posedge clock) tristate);
endmodule : aof_formatter

// >>> sim/aof_asic_sink.sv
`timescale 1ns/1ps
module aof_asic_sink (
    input wire logic clock,
    input wire logic [9:0] pins,
    output logic [9:0] word
);
    // Takes in whatever the pins show on each rising edge
    always_ff @(posedge clock) begin
        word <= pins;
    end
endmodule : aof_asic_sink

// >>> sim/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
 n_mismatch++; $display("Error %0t %h %h", $time, a, e); end end
module tb;
    import aof_pkg::*;
    logic clock = 0, nrst = 0, reg_write = 0, reg_read = 0, pixel_start = 0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, v;
    logic [DATA_W-1:0] conv_data = '0, data_out, data_oe, word;
    tri1 [DATA_W-1:0] pins;
    int n_mismatch = 0, check_count = 0, cyc = 0;
    // Pulled-up pins, each driven only while its enable is high
    for (genvar i = 0; i < DATA_W; i++) begin : g_pin
        assign pins[i] = data_oe[i] ? data_out[i] : 1'bz;
    end
    aof_formatter DUT (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .pixel_start(pixel_start),
        .conv_data(conv_data), .data_out(data_out), .data_oe(data_oe));
    aof_asic_sink sink (.clock(clock), .pins(pins), .word(word));
    always #2 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clock);
        reg_write <= 0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        {reg_read, reg_addr} <= {1'b1, a};
        @(posedge clock);
        reg_read <= 0;
        #1 v = reg_rdata;
    endtask : rd
    function automatic logic [9:0] gray(input logic [9:0] b);
        return b ^ {1'b0, b[9:1]};
    endfunction : gray
    task automatic t_stream(input logic [31:0] c);
        wr(CTRL_ADDR, c);
        for (int i = 0; i < 12; i++) begin
            @(posedge clock);
            conv_data <= 10'(i * 93 + 1);
            @(posedge clock);
            #1;
            `CHK(data_out, c[5] ? gray(10'(i * 93 + 1)) : 10'(i * 93 + 1))
        end
    endtask : t_stream
    task automatic t_latch();
        wr(CTRL_ADDR, 32'h0);
        wr(PHASE_ADDR, 32'h2);
        @(posedge clock);
        {pixel_start, conv_data} <= {1'b1, 10'h111};
        @(posedge clock);
        {pixel_start, conv_data} <= {1'b0, 10'h222};
        @(posedge clock);
        conv_data <= 10'h3c5;
        @(posedge clock);
        conv_data <= 10'h0aa;
        repeat (4) @(posedge clock);
        #1;
        `CHK(data_out, 10'h3c5)
        `CHK(word, 10'h3c5)
        rd(STATUS_ADDR);
        `CHK(v[9:0], 10'h3c5)
    endtask : t_latch
    task automatic t_float();
        wr(CTRL_ADDR, 32'h08);
        #1;
        `CHK(data_oe, 10'h000)
        `CHK(pins, 10'h3ff)
        rd(CTRL_ADDR);
        `CHK(v[7:0], 8'h08)
    endtask : t_float
    task automatic print_verdict();
        if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (4) @(posedge clock);
        nrst <= 1;
        #1;
        `CHK(data_oe, 10'h3ff)
        t_stream(32'h10);
        t_stream(32'h30);
        t_latch();
        t_float();
        print_verdict();
    end
endmodule : tb
